/* arp_pkg.sv */
// shared constants for the converter result readout port
package arp_pkg;
  localparam int NUM_CH = 8;
  localparam int RES_W = 18;
  localparam int PAR_W = 16;
  localparam int PAR_WORDS = 16;
  localparam int BITS_PER_CH = 18;
  localparam int DUAL_CYCLES = 72;
  localparam int SINGLE_CYCLES = 144;
  localparam logic SEL_PARALLEL = 1'b0;
  localparam logic SEL_SERIAL = 1'b1;
  // bit positions inside the device pin synchroniser
  localparam int PIN_CS = 0;
  localparam int PIN_RD = 1;
  localparam int PIN_SEL = 2;
  localparam int PIN_START = 3;
  localparam logic [3:0] PIN_SYNC_RESET = 4'h3;
  // conversion time is not fixed here; plain default
  localparam int CLOCK_NS = 8;
  localparam int CONV_TIME_NS = 4000;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int SLOT_CLEAR_CYCLES = 3;
  // host strobe and serial clock shaping, in host clock cycles
  localparam int SCLK_HALF = 4;
  localparam int STROBE_LOW = 8;
  localparam int STROBE_HIGH = 4;
endpackage : arp_pkg

/* arp_if.sv */
// link between the converter readout port and its digital host
`timescale 1ns/1ps
`default_nettype none
interface arp_if
  import arp_pkg::*;
();
  logic interfaceSelect;
  logic csN;
  logic rdN;
  logic sclk;
  logic busy;
  logic [PAR_W-1:0] parallelData;
  logic parallelDataOe;
  logic serialOutA;
  logic serialOutAOe;
  logic serialOutB;
  logic serialOutBOe;
  logic firstChannelFlag;
  logic firstChannelFlagOe;

  modport device (
    input interfaceSelect, csN, rdN, sclk,
    output busy, parallelData, parallelDataOe, serialOutA, serialOutAOe,
    output serialOutB, serialOutBOe, firstChannelFlag, firstChannelFlagOe
  );
  modport host (
    output interfaceSelect, csN, rdN, sclk,
    input busy, parallelData, parallelDataOe, serialOutA, serialOutAOe,
    input serialOutB, serialOutBOe, firstChannelFlag, firstChannelFlagOe
  );
endinterface : arp_if
`default_nettype wire

/* arp_device.sv */
// converter end of the readout port: busy, result store, parallel and serial readout
//
// Functional notes
// - select pin low parallel, high serial
// - bus driven only while select and read low
// - select rise floats bus, fall releases
// - two strobes per channel, high then low bits
// - sixteen strobes read eight channels ascending
// - host reads after busy falls or during busy
// - joined select and read strobe each word
// - serial select fall drives first result bit
// - later bits shift on rising serial clock
// - host gives eighteen clocks per result
// - select held low or pulsed per channel
// - output A channels one-four, B five-eight
// - dual outputs read all in 72 clocks
// - single output needs 144 clocks, A preferred
// - output B alone: five to eight, then one-four
// - first flag floats when deselected, marks channel one
// - first flag only for channel one on A
// - no read on busy falling edge
// - busy rises on start, falls when done
// - all channels always present in readout
`timescale 1ns/1ps
`default_nettype none
module arp_device
  import arp_pkg::*;
#(
  parameter int ConvCycles = CONV_CYCLES
)
(
  input wire logic clock,
  input wire logic rst,
  arp_if.device link,
  input wire logic conversionStart,
  input wire logic [NUM_CH*RES_W-1:0] channelResults,
  output logic resultsLoaded
);

  localparam int CntW = $clog2(ConvCycles + 1);

  // ************************************************************
  // pin synchronisers (main clock)
  // ************************************************************
  logic [3:0] pinMeta_q;
  logic [3:0] pinSync_q;
  logic [3:0] pinPrev_q;
  wire [3:0] pinRaw = {conversionStart, link.interfaceSelect, link.rdN, link.csN};

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pinMeta_q <= PIN_SYNC_RESET;
      pinSync_q <= PIN_SYNC_RESET;
      pinPrev_q <= PIN_SYNC_RESET;
    end
    else
    begin
      pinMeta_q <= pinRaw;
      pinSync_q <= pinMeta_q;
      pinPrev_q <= pinSync_q;
    end
  end

  wire startRise = pinSync_q[PIN_START] & ~pinPrev_q[PIN_START];
  wire parMode = (pinSync_q[PIN_SEL] == SEL_PARALLEL);
  wire strobeNow = ~pinSync_q[PIN_CS] & ~pinSync_q[PIN_RD];
  wire strobeWas = ~pinPrev_q[PIN_CS] & ~pinPrev_q[PIN_RD];
  // a joined select/read pulse looks the same as a read under a held select
  wire strobeStart = strobeNow & ~strobeWas;

  // ************************************************************
  // conversion busy and result store
  // ************************************************************
  logic busy_q;
  logic [CntW-1:0] convCnt_q;
  logic [NUM_CH*RES_W-1:0] results_q;
  logic loaded_q;
  wire convDone = busy_q && (convCnt_q == CntW'(ConvCycles - 1));

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      busy_q <= 1'b0;
      convCnt_q <= '0;
    end
    else if (startRise && !busy_q)
    begin
      busy_q <= 1'b1;
      convCnt_q <= '0;
    end
    else if (busy_q)
    begin
      convCnt_q <= convCnt_q + 1'b1;
      if (convDone)
      begin
        busy_q <= 1'b0;
      end
    end
  end

  // the old results stay readable until the busy fall replaces all of them
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      results_q <= '0;
      loaded_q <= 1'b0;
    end
    else
    begin
      loaded_q <= convDone;
      if (convDone)
      begin
        results_q <= channelResults;
      end
    end
  end

  // ************************************************************
  // parallel readout
  // ************************************************************
  logic [3:0] wordIdx_q;
  logic [PAR_W-1:0] parData_q;
  logic parOe_q;
  wire [2:0] parCh = wordIdx_q[3:1];
  wire [RES_W-1:0] parChWord = results_q[parCh*RES_W +: RES_W];
  wire [PAR_W-1:0] parHigh = parChWord[RES_W-1:2];
  wire [PAR_W-1:0] parLow = {{(PAR_W-2){1'b0}}, parChWord[1:0]};
  wire [PAR_W-1:0] parWord = wordIdx_q[0] ? parLow : parHigh;

  always_ff @(posedge clock)
  begin
    if (rst || convDone)
    begin
      wordIdx_q <= '0;
    end
    else if (strobeStart && parMode)
    begin
      // four bits wrap after the sixteenth word
      wordIdx_q <= wordIdx_q + 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      parData_q <= '0;
      parOe_q <= 1'b0;
    end
    else
    begin
      if (strobeStart && parMode)
      begin
        parData_q <= parWord;
      end
      parOe_q <= parMode & strobeNow;
    end
  end

  // ************************************************************
  // serial slot clear, main clock
  // ************************************************************
  // held a few cycles so the link side sees a clean async clear
  logic [1:0] clearCnt_q;
  logic slotClear_q;

  always_ff @(posedge clock)
  begin
    if (rst || convDone)
    begin
      clearCnt_q <= 2'(SLOT_CLEAR_CYCLES - 1);
      slotClear_q <= 1'b1;
    end
    else if (clearCnt_q != 2'h0)
    begin
      clearCnt_q <= clearCnt_q - 2'h1;
    end
    else
    begin
      slotClear_q <= 1'b0;
    end
  end

  // ************************************************************
  // serial readout, link clock
  // ************************************************************
  logic [4:0] bitCnt_q;
  logic [2:0] slot_q;
  wire lastBit = (bitCnt_q == 5'(BITS_PER_CH - 1));

  // a raised select restarts the bit count; the frame carries no idle edges
  always_ff @(posedge link.sclk or posedge link.csN)
  begin
    if (link.csN)
    begin
      bitCnt_q <= 5'h00;
    end
    else if (lastBit)
    begin
      bitCnt_q <= 5'h00;
    end
    else
    begin
      bitCnt_q <= bitCnt_q + 5'h01;
    end
  end

  // slot survives select pulses so per-channel framing walks on
  always_ff @(posedge link.sclk or posedge slotClear_q)
  begin
    if (slotClear_q)
    begin
      slot_q <= 3'h0;
    end
    else if (lastBit)
    begin
      slot_q <= slot_q + 3'h1;
    end
  end

  wire [2:0] chA = slot_q;
  wire [2:0] chB = slot_q + 3'h4;
  wire [7:0] bitIdxA = 8'(chA * RES_W + (RES_W - 1) - bitCnt_q);
  wire [7:0] bitIdxB = 8'(chB * RES_W + (RES_W - 1) - bitCnt_q);
  wire serActive = ~link.csN & (link.interfaceSelect == SEL_SERIAL);

  // ************************************************************
  // pin drive
  // ************************************************************
  // serial pins follow select and the shift count directly: no clock edge
  // exists between the select fall and the first sampling edge
  assign link.busy = busy_q;
  assign link.parallelData = parData_q;
  assign link.parallelDataOe = parOe_q;
  assign link.serialOutA = results_q[bitIdxA];
  assign link.serialOutB = results_q[bitIdxB];
  assign link.serialOutAOe = serActive;
  assign link.serialOutBOe = serActive;
  assign link.firstChannelFlag = (slot_q == 3'h0);
  assign link.firstChannelFlagOe = serActive;
  assign resultsLoaded = loaded_q;

endmodule : arp_device
`default_nettype wire

/* arp_host.sv */
// host end of the readout port: strobes or serial clock, collects all channels
`timescale 1ns/1ps
`default_nettype none
module arp_host
  import arp_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  arp_if.host link,
  input wire logic useSerial,
  input wire logic useDual,
  input wire logic frameEach,
  input wire logic readStart,
  output logic [NUM_CH*RES_W-1:0] results,
  output logic resultsDone,
  output logic busySeen,
  output logic readBusy
);

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_PAR_LOW = 3'b001,
    HS_PAR_HIGH = 3'b010,
    HS_SER_LEAD = 3'b011,
    HS_SER_LOW = 3'b100,
    HS_SER_HIGH = 3'b101,
    HS_SER_GAP = 3'b110,
    HS_DONE = 3'b111
  } arp_host_state_type;

  // ************************************************************
  // input synchronisers
  // ************************************************************
  localparam int SyncW = PAR_W + 3;
  logic [SyncW-1:0] inMeta_q;
  logic [SyncW-1:0] inSync_q;
  wire [SyncW-1:0] inRaw = {link.busy, link.serialOutB, link.serialOutA, link.parallelData};

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      inMeta_q <= '0;
      inSync_q <= '0;
    end
    else
    begin
      inMeta_q <= inRaw;
      inSync_q <= inMeta_q;
    end
  end

  wire [PAR_W-1:0] parIn = inSync_q[PAR_W-1:0];
  wire serA = inSync_q[PAR_W];
  wire serB = inSync_q[PAR_W+1];

  // ************************************************************
  // sequencer
  // ************************************************************
  arp_host_state_type state_q;
  logic [3:0] tmr_q;
  logic [3:0] cnt_q;
  logic [4:0] bitCnt_q;
  logic [PAR_W-1:0] hiPart_q;
  logic [RES_W-1:0] shA_q;
  logic [RES_W-1:0] shB_q;
  logic sel_q;
  logic dual_q;
  logic each_q;
  logic csN_q;
  logic rdN_q;
  logic sclk_q;
  logic done_q;
  logic [NUM_CH*RES_W-1:0] res_q;

  wire halfUp = (tmr_q == 4'(SCLK_HALF - 1));
  wire lowUp = (tmr_q == 4'(STROBE_LOW - 1));
  wire highUp = (tmr_q == 4'(STROBE_HIGH - 1));
  wire chFull = (bitCnt_q == 5'(BITS_PER_CH));
  wire [3:0] lastCh = dual_q ? 4'(NUM_CH / 2 - 1) : 4'(NUM_CH - 1);
  wire [2:0] parCh = cnt_q[3:1];

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q <= HS_IDLE;
      tmr_q <= '0;
      cnt_q <= '0;
      bitCnt_q <= '0;
      hiPart_q <= '0;
      shA_q <= '0;
      shB_q <= '0;
      sel_q <= SEL_PARALLEL;
      dual_q <= 1'b0;
      each_q <= 1'b0;
      csN_q <= 1'b1;
      rdN_q <= 1'b1;
      sclk_q <= 1'b1;
      done_q <= 1'b0;
      res_q <= '0;
    end
    else
    begin
      done_q <= 1'b0;
      tmr_q <= tmr_q + 4'h1;
      case (state_q)
        HS_IDLE:
        begin
          sel_q <= useSerial ? SEL_SERIAL : SEL_PARALLEL;
          dual_q <= useDual;
          each_q <= frameEach;
          cnt_q <= '0;
          bitCnt_q <= '0;
          tmr_q <= '0;
          if (readStart)
          begin
            csN_q <= 1'b0;
            rdN_q <= sel_q;
            state_q <= (sel_q == SEL_SERIAL) ? HS_SER_LEAD : HS_PAR_LOW;
          end
        end
        HS_PAR_LOW:
        begin
          if (lowUp)
          begin
            if (!cnt_q[0])
            begin
              hiPart_q <= parIn;
            end
            else
            begin
              res_q[parCh*RES_W +: RES_W] <= {hiPart_q, parIn[1:0]};
            end
            csN_q <= 1'b1;
            rdN_q <= 1'b1;
            tmr_q <= '0;
            state_q <= HS_PAR_HIGH;
          end
        end
        HS_PAR_HIGH:
        begin
          if (highUp)
          begin
            cnt_q <= cnt_q + 4'h1;
            tmr_q <= '0;
            if (cnt_q == 4'(PAR_WORDS - 1))
            begin
              state_q <= HS_DONE;
            end
            else
            begin
              csN_q <= 1'b0;
              rdN_q <= 1'b0;
              state_q <= HS_PAR_LOW;
            end
          end
        end
        HS_SER_LEAD, HS_SER_HIGH:
        begin
          if (halfUp)
          begin
            tmr_q <= '0;
            if (chFull)
            begin
              res_q[cnt_q[2:0]*RES_W +: RES_W] <= shA_q;
              if (dual_q)
              begin
                res_q[(cnt_q[2:0]+3'h4)*RES_W +: RES_W] <= shB_q;
              end
              cnt_q <= cnt_q + 4'h1;
              bitCnt_q <= '0;
            end
            if (chFull && (cnt_q == lastCh))
            begin
              csN_q <= 1'b1;
              state_q <= HS_DONE;
            end
            else if (chFull && each_q)
            begin
              csN_q <= 1'b1;
              state_q <= HS_SER_GAP;
            end
            else
            begin
              // sample on our own falling edge, one half after the shift
              sclk_q <= 1'b0;
              shA_q <= {shA_q[RES_W-2:0], serA};
              shB_q <= {shB_q[RES_W-2:0], serB};
              bitCnt_q <= chFull ? 5'h01 : bitCnt_q + 5'h01;
              state_q <= HS_SER_LOW;
            end
          end
        end
        HS_SER_LOW:
        begin
          if (halfUp)
          begin
            sclk_q <= 1'b1;
            tmr_q <= '0;
            state_q <= HS_SER_HIGH;
          end
        end
        HS_SER_GAP:
        begin
          if (halfUp)
          begin
            csN_q <= 1'b0;
            tmr_q <= '0;
            state_q <= HS_SER_LEAD;
          end
        end
        HS_DONE:
        begin
          done_q <= 1'b1;
          state_q <= HS_IDLE;
        end
        default:
        begin
          state_q <= HS_IDLE;
        end
      endcase
    end
  end

  logic busySeen_q;
  logic readBusy_q;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      busySeen_q <= 1'b0;
      readBusy_q <= 1'b0;
    end
    else
    begin
      busySeen_q <= inSync_q[PAR_W+2];
      readBusy_q <= (state_q != HS_IDLE);
    end
  end

  assign link.interfaceSelect = sel_q;
  assign link.csN = csN_q;
  assign link.rdN = rdN_q;
  assign link.sclk = sclk_q;
  assign results = res_q;
  assign resultsDone = done_q;
  assign busySeen = busySeen_q;
  assign readBusy = readBusy_q;

endmodule : arp_host
`default_nettype wire

/* arp_link_sva.sv */
// assertions on the readout link between the converter end and the host end
`timescale 1ns/1ps
`default_nettype none
module arp_link_sva
  import arp_pkg::*;
#(
  parameter int ConvCycles = CONV_CYCLES
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic conversionStart,
  input wire logic interfaceSelect,
  input wire logic csN,
  input wire logic rdN,
  input wire logic sclk,
  input wire logic busy,
  input wire logic parallelDataOe,
  input wire logic serialOutAOe,
  input wire logic serialOutBOe,
  input wire logic firstChannelFlag,
  input wire logic firstChannelFlagOe
);
  // ****************************************
  // helper counters
  // ****************************************
  logic sclkPrev_q;
  logic busyPrev_q;
  logic [7:0] riseCnt_q;
  logic [15:0] busyCnt_q;
  // device slot moves on the same rise that this edge sees, so count it now
  wire logic riseNow = sclk && !sclkPrev_q && !csN && interfaceSelect;
  wire logic [8:0] riseSum = {1'b0, riseCnt_q} + {8'h00, riseNow};
  wire logic flagExp = (riseSum < 9'h012) || (riseSum == 9'h090);
  wire logic busyFall = busyPrev_q && !busy;
  wire logic [7:0] riseCnt_d = (busyFall || riseSum == 9'h090) ? 8'h00 : riseSum[7:0];
  wire logic [15:0] busyCnt_d = busy ? busyCnt_q + 16'h0001 : 16'h0000;

  always_ff @(posedge clock)
    if (rst)
    begin
      sclkPrev_q <= 1'b1;
      busyPrev_q <= 1'b0;
      riseCnt_q <= 8'h00;
      busyCnt_q <= 16'h0000;
    end
    else
    begin
      sclkPrev_q <= sclk;
      busyPrev_q <= busy;
      riseCnt_q <= riseCnt_d;
      busyCnt_q <= busyCnt_d;
    end

  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_par_oe_rise: assert property ($rose(parallelDataOe) |->
    $past(!csN && !rdN, 3) && !interfaceSelect)
    else $error("parallel bus enabled without select and read low");
  a_par_oe_drop: assert property ((csN || rdN) [*4] |-> !parallelDataOe)
    else $error("parallel bus still driven after release");
  a_ser_mode_quiet: assert property (interfaceSelect |-> !parallelDataOe)
    else $error("parallel bus driven in serial mode");
  a_ser_oe_sel: assert property ((serialOutAOe && serialOutBOe) ==
    (!csN && interfaceSelect))
    else $error("serial outputs enabled wrongly");
  a_flag_float: assert property (csN |-> !firstChannelFlagOe)
    else $error("first flag driven while deselected");
  a_flag_value: assert property (firstChannelFlagOe |->
    firstChannelFlag == flagExp)
    else $error("first flag level wrong for slot");
  a_busy_rise: assert property ($rose(conversionStart) && !busy |-> ##[2:5] busy)
    else $error("busy did not rise after start");
  a_busy_len: assert property ($fell(busy) |-> busyCnt_q == ConvCycles)
    else $error("busy high time wrong");
  a_sclk_idle: assert property (csN |-> sclk)
    else $error("serial clock not idle high outside frame");
endmodule : arp_link_sva
`default_nettype wire

/* tb.sv */
// self-checking bench: converter end and host end joined by the readout link
`timescale 1ns/1ps
`default_nettype none
module tb
  import arp_pkg::*;
;
  // kept short, yet long enough that a parallel read fits inside one busy period
  localparam int ConvSmall = 300;
  logic clock, rst, conversionStart, useSerial, useDual, frameEach, readStart;
  logic [NUM_CH*RES_W-1:0] channelResults, hostResults, prevSet, monV;
  logic resultsLoaded, resultsDone, busySeen, readBusy;
  logic [159:0] rnd;
  logic [1:0] firstBits;
  int seed = 94;
  int fail_count = 0;
  int samples_checked = 0;
  int sclkFalls, rdFalls, i, loadCount, convCount;
  logic [NUM_CH*RES_W-1:0] expQ[$];
  int cntQ[$];

  arp_if link ();
  arp_device #(.ConvCycles(ConvSmall)) u_arp_device (.clock(clock), .rst(rst), .link(link),
    .conversionStart(conversionStart), .channelResults(channelResults),
    .resultsLoaded(resultsLoaded));
  arp_host u_arp_host (.clock(clock), .rst(rst), .link(link), .useSerial(useSerial),
    .useDual(useDual), .frameEach(frameEach), .readStart(readStart), .results(hostResults),
    .resultsDone(resultsDone), .busySeen(busySeen), .readBusy(readBusy));
  arp_link_sva #(.ConvCycles(ConvSmall)) u_arp_link_sva (.clock(clock), .rst(rst),
    .conversionStart(conversionStart), .interfaceSelect(link.interfaceSelect),
    .csN(link.csN), .rdN(link.rdN), .sclk(link.sclk), .busy(link.busy),
    .parallelDataOe(link.parallelDataOe), .serialOutAOe(link.serialOutAOe),
    .serialOutBOe(link.serialOutBOe), .firstChannelFlag(link.firstChannelFlag),
    .firstChannelFlagOe(link.firstChannelFlagOe));

  // ****************************************
  // tasks
  // ****************************************
  task automatic results();
    if (fail_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  task automatic timeout();
    fail_count++;
    results();
  endtask : timeout

  task automatic compareVal(input string what, input logic [143:0] expV,
    input logic [143:0] gotV);
    samples_checked++;
    if (gotV !== expV)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, expV, gotV);
    end
  endtask : compareVal

  task automatic convert();
    int n;
    convCount++;
    prevSet = channelResults;
    for (n = 0; n < 5; n++)
      rnd[n*32 +: 32] = $random(seed);
    channelResults = rnd[143:0];
    conversionStart = 1'b1;
    for (n = 0; n < 10 && link.busy !== 1'b1; n++)
      @(negedge clock);
    if (link.busy !== 1'b1)
      timeout();
    conversionStart = 1'b0;
    repeat (4) @(negedge clock);
    compareVal("busy seen", 1'b1, busySeen);
  endtask : convert

  task automatic waitBusyLow();
    int n;
    for (n = 0; n < 400 && link.busy !== 1'b0; n++)
      @(negedge clock);
    if (link.busy !== 1'b0)
      timeout();
    repeat (4) @(negedge clock);
    compareVal("busy seen", 1'b0, busySeen);
  endtask : waitBusyLow

  task automatic readSet(input logic ser, input logic dual, input logic each,
    input logic [143:0] expV);
    int n;
    useSerial = ser;
    useDual = dual;
    frameEach = each;
    repeat (4) @(negedge clock);
    sclkFalls = 0;
    rdFalls = 0;
    expQ.push_back(expV);
    cntQ.push_back(!ser ? PAR_WORDS : (dual ? DUAL_CYCLES : SINGLE_CYCLES));
    readStart = 1'b1;
    @(negedge clock);
    readStart = 1'b0;
    for (n = 0; n < 3000 && expQ.size() > 0; n++)
      @(negedge clock);
    if (expQ.size() > 0)
      timeout();
  endtask : readSet

  // ****************************************
  // link watchers and result checker
  // ****************************************
  always @(negedge link.sclk)
    if (link.csN === 1'b0)
    begin
      if (sclkFalls == 0)
        firstBits = {link.serialOutA, link.serialOutB};
      sclkFalls++;
    end

  always @(negedge link.rdN)
    rdFalls++;

  always @(negedge clock)
    if (resultsLoaded === 1'b1)
      loadCount++;

  // negedge keeps the pulse sampling clear of the launching edge
  always @(negedge clock)
    if (resultsDone === 1'b1 && expQ.size() > 0)
    begin
      monV = expQ.pop_front();
      compareVal("results", monV, hostResults);
      compareVal("read busy", 1'b1, readBusy);
      compareVal("edges", cntQ.pop_front(), useSerial ? sclkFalls : rdFalls);
      if (useSerial === 1'b1)
        compareVal("first bits", {monV[17], monV[89]}, firstBits);
    end

  // ****************************************
  // stimulus
  // ****************************************
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  initial
  begin
    rst = 1'b1;
    conversionStart = 1'b0;
    useSerial = 1'b0;
    useDual = 1'b0;
    frameEach = 1'b0;
    readStart = 1'b0;
    channelResults = '0;
    repeat (4) @(negedge clock);
    rst = 1'b0;
    repeat (3) @(negedge clock);
    for (i = 0; i < 5; i++)
    begin
      convert();
      waitBusyLow();
      readSet(i != 0, 1'(i & 1), 1'(i >> 1), channelResults);
    end
    // a read inside busy, clear of its falling edge, then a read after busy falls
    convert();
    readSet(1'b0, 1'b0, 1'b0, prevSet);
    waitBusyLow();
    readSet(1'b1, 1'b1, 1'b1, channelResults);
    compareVal("loads", convCount, loadCount);
    results();
  end
endmodule : tb
`default_nettype wire
